// ### hw/monitor_periph_map.svh
// Address map, field positions and reset values of the monitor register bank
`ifndef MONITOR_PERIPH_MAP_SVH
`define MONITOR_PERIPH_MAP_SVH

// ==========================================================
// Register addresses in external data space
`define ADDR_PORT1_SEL       8'h82
`define ADDR_PORT2_SEL       8'h83
`define ADDR_PORT3_SEL       8'h84
`define ADDR_PARA_LOW        8'h85
`define ADDR_PARA_HIGH       8'h86
`define ADDR_HCOUNT_LOW      8'h87
`define ADDR_HCOUNT_HIGH     8'h88
`define ADDR_VCOUNT_LOW      8'h89
`define ADDR_VCOUNT_HIGH     8'h8A
`define ADDR_SOA_LOW         8'h8C
`define ADDR_SOA_CLEAR       8'h8E
`define ADDR_IRQ_MASK        8'h8F
`define ADDR_IRQ_FLAGS       8'h90
`define ADDR_IRQ_CLEAR       8'h91

// ==========================================================
// Field positions
`define IRQ_COUNT            6
`define IRQ_CLOCK_LINE_LOW   0
`define IRQ_CONVERSION_DONE  1
`define IRQ_DISPLAY_EMPTY    2
`define IRQ_SAFE_AREA        3
`define IRQ_VERTICAL_EVENT   4
`define IRQ_PARABOLA_TICK    5
`define P2_PWM_BITS          3
`define P2_CLAMP_BIT         3
`define P2_ADC_LSB           4
`define P3_HSYNC_BIT         3
`define P3_VSYNC_BIT         4
`define COUNT_WIDTH          12
`define PARA_WIDTH           13
`define PARA_HIGH_WIDTH      5
`define SOA_WIDTH            6
`define SYNC_ABSENT_BIT      6
`define SYNC_POLARITY_BIT    7
`define SOA_ABOVE_BIT        6
`define SOA_BELOW_BIT        7

// ==========================================================
// Reset values
`define RST_PIN_SELECT       8'h00
`define RST_PARA             13'h0000
`define RST_IRQ_MASK         6'h00
`define RST_IRQ_FLAGS        6'h00
`define RST_SOA_LOW          6'h00
`define RST_READ_DATA        8'h00

`endif

// ### hw/monitor_periph_pkg.sv
// Types shared by the monitor register bank
package monitor_periph_pkg;
`include "monitor_periph_map.svh"

   typedef logic [`IRQ_COUNT-1:0] irq_vec_t;

   // Sync processor measurements, same clock domain
   typedef struct packed {
      logic [`COUNT_WIDTH-1:0] hcount;
      logic                    hsync_absent;
      logic                    hsync_input_polarity;
      logic [`COUNT_WIDTH-1:0] vcount;
      logic                    vsync_absent;
      logic                    vsync_input_polarity;
   } sync_status_s;

   // CPU external data access
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } xdata_req_s;

   typedef struct packed {
      irq_vec_t flags;
      logic     irq;
   } flag_state_s;

   typedef struct packed {
      logic [7:0]              port1_pin_function_select;
      logic [7:0]              port2_pin_function_select;
      logic [1:0]              port3_pin_function_select;
      logic [`PARA_WIDTH-1:0]  parabola_period;
      irq_vec_t                irq_enable_mask;
      logic [`SOA_WIDTH-1:0]   safe_area_low_threshold;
      logic                    vsync_absent_seen;
      logic [7:0]              read_data;
      logic [7:0]              port1_pins;
      logic [7:0]              port2_pins;
      logic [3:0]              port2_analog;
      logic [7:0]              port3_pins;
   } bank_state_s;

endpackage : monitor_periph_pkg

// ### hw/irq_flag_bank.sv
// Sticky interrupt flags with mask gating and write-one clear
`timescale 1ns/1ps
`include "monitor_periph_map.svh"

module irq_flag_bank (
   // Clock and reset
   input  wire logic                        ref_clk_in,
   input  wire logic                        rst_b_in,
   // Events, clears and mask
   input  wire monitor_periph_pkg::irq_vec_t set_in,
   input  wire monitor_periph_pkg::irq_vec_t clear_in,
   input  wire monitor_periph_pkg::irq_vec_t mask_in,
   // Flags and request
   output monitor_periph_pkg::irq_vec_t     flags_out,
   output logic                              irq_out
);
   import monitor_periph_pkg::*;

   flag_state_s state;
   flag_state_s next_state;

   // ==========================================================
   // Next state
   always_comb begin
      next_state = state;
      // Set wins over a clear in the same cycle
      next_state.flags = (state.flags & ~clear_in) | set_in;
      next_state.irq   = |(next_state.flags & mask_in);
   end

   // ==========================================================
   // Registers
   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state.flags <= `RST_IRQ_FLAGS;
         state.irq   <= 1'b0;
      end else begin
         state <= next_state;
      end
   end

   assign flags_out = state.flags;
   assign irq_out   = state.irq;

endmodule : irq_flag_bank

// ### hw/monitor_periph_status_regs.sv
// Monitor peripheral register bank: pin selects, sync counts, interrupts
`timescale 1ns/1ps
`include "monitor_periph_map.svh"

module monitor_periph_status_regs (
   // Clock and reset
   input  wire logic                             ref_clk_in,
   input  wire logic                             rst_b_in,
   // CPU external data access
   input  wire monitor_periph_pkg::xdata_req_s   xdata_req_in,
   output logic [7:0]                            xdata_rdata_out,
   output logic                                  irq_out,
   // Sync processor status and events
   input  wire monitor_periph_pkg::sync_status_s sync_status_in,
   input  wire logic                             vsync_pulse_in,
   input  wire logic [`SOA_WIDTH-1:0]            soa_high_threshold_in,
   input  wire logic                             clock_line_low_in,
   input  wire logic                             conversion_done_in,
   input  wire logic                             display_empty_in,
   input  wire logic                             safe_area_event_in,
   input  wire logic                             parabola_tick_in,
   // Pin sources
   input  wire logic [7:0]                       port1_data_in,
   input  wire logic [7:0]                       port2_data_in,
   input  wire logic [7:0]                       port3_data_in,
   input  wire logic [10:0]                      pwm_in,
   input  wire logic                             hclamp_in,
   input  wire logic                             horizontal_sync_out_in,
   input  wire logic                             vertical_sync_out_in,
   // Pin drives and settings
   output logic [7:0]                            port1_pin_out,
   output logic [7:0]                            port2_pin_out,
   output logic [3:0]                            port2_analog_out,
   output logic [7:0]                            port3_pin_out,
   output logic [`PARA_WIDTH-1:0]                parabola_period_out,
   output logic [`SOA_WIDTH-1:0]                 soa_low_threshold_out
);
   import monitor_periph_pkg::*;

   bank_state_s state;
   bank_state_s next_state;
   irq_vec_t    irq_set;
   irq_vec_t    irq_clear;
   irq_vec_t    irq_flags;
   logic        irq_req;
   logic        above_low_threshold;
   logic        below_high_threshold;
   logic        vsync_absent_rise;
   logic [7:0]  read_value;

   // ==========================================================
   // Address decode
   function automatic logic hit(input xdata_req_s req,
                                input logic [7:0] addr);
      hit = req.addr == addr;
   endfunction : hit

   function automatic logic wr_hit(input xdata_req_s req,
                                   input logic [7:0] addr);
      wr_hit = req.wr && hit(req, addr);
   endfunction : wr_hit

   // ==========================================================
   // Safe-area comparisons on the upper count bits
   assign above_low_threshold =
      sync_status_in.hcount[`COUNT_WIDTH-1 -: `SOA_WIDTH]
      > state.safe_area_low_threshold;
   assign below_high_threshold =
      sync_status_in.hcount[`COUNT_WIDTH-1 -: `SOA_WIDTH]
      < soa_high_threshold_in;

   // ==========================================================
   // Interrupt events and clears
   assign vsync_absent_rise = sync_status_in.vsync_absent &&
                              !state.vsync_absent_seen;

   always_comb begin
      irq_set = '0;
      irq_set[`IRQ_CLOCK_LINE_LOW]  = clock_line_low_in;
      irq_set[`IRQ_CONVERSION_DONE] = conversion_done_in;
      irq_set[`IRQ_DISPLAY_EMPTY]   = display_empty_in;
      irq_set[`IRQ_SAFE_AREA]       = safe_area_event_in;
      irq_set[`IRQ_VERTICAL_EVENT]  = vsync_pulse_in ||
                                      vsync_absent_rise;
      irq_set[`IRQ_PARABOLA_TICK]   = parabola_tick_in;
   end

   always_comb begin
      irq_clear = '0;
      if (wr_hit(xdata_req_in, `ADDR_IRQ_CLEAR)) begin
         irq_clear = xdata_req_in.wdata[`IRQ_COUNT-1:0];
      end
      if (wr_hit(xdata_req_in, `ADDR_SOA_CLEAR)) begin
         irq_clear[`IRQ_SAFE_AREA] = 1'b1;
      end
   end

   irq_flag_bank u_flags (
      .ref_clk_in (ref_clk_in),
      .rst_b_in   (rst_b_in),
      .set_in     (irq_set),
      .clear_in   (irq_clear),
      .mask_in    (state.irq_enable_mask),
      .flags_out  (irq_flags),
      .irq_out    (irq_req)
   );

   // ==========================================================
   // Read multiplexer
   always_comb begin
      read_value = 8'h00;
      case (xdata_req_in.addr)
         `ADDR_HCOUNT_LOW: begin
            read_value = sync_status_in.hcount[7:0];
         end
         `ADDR_HCOUNT_HIGH: begin
            read_value[3:0] = sync_status_in.hcount[11:8];
            read_value[`SYNC_ABSENT_BIT] =
               sync_status_in.hsync_absent;
            read_value[`SYNC_POLARITY_BIT] =
               sync_status_in.hsync_input_polarity;
         end
         `ADDR_VCOUNT_LOW: begin
            read_value = sync_status_in.vcount[7:0];
         end
         `ADDR_VCOUNT_HIGH: begin
            read_value[3:0] = sync_status_in.vcount[11:8];
            read_value[`SYNC_ABSENT_BIT] =
               sync_status_in.vsync_absent;
            read_value[`SYNC_POLARITY_BIT] =
               sync_status_in.vsync_input_polarity;
         end
         `ADDR_IRQ_FLAGS: begin
            read_value[`IRQ_COUNT-1:0] = irq_flags;
         end
         `ADDR_IRQ_MASK: begin
            read_value[`IRQ_COUNT-1:0] =
               state.irq_enable_mask;
         end
         `ADDR_PARA_LOW: begin
            read_value = state.parabola_period[7:0];
         end
         `ADDR_PARA_HIGH: begin
            read_value[`PARA_HIGH_WIDTH-1:0] =
               state.parabola_period[`PARA_WIDTH-1:8];
         end
         `ADDR_SOA_LOW: begin
            read_value[`SOA_WIDTH-1:0] =
               state.safe_area_low_threshold;
            read_value[`SOA_ABOVE_BIT] = above_low_threshold;
            read_value[`SOA_BELOW_BIT] = below_high_threshold;
         end
         // Pin selects and clear addresses read as zero
         default: begin
            read_value = 8'h00;
         end
      endcase
   end

   // ==========================================================
   // Next state
   always_comb begin
      next_state = state;
      next_state.vsync_absent_seen =
         sync_status_in.vsync_absent;
      if (xdata_req_in.rd) begin
         next_state.read_data = read_value;
      end
      if (wr_hit(xdata_req_in, `ADDR_PORT1_SEL)) begin
         next_state.port1_pin_function_select =
            xdata_req_in.wdata;
      end
      if (wr_hit(xdata_req_in, `ADDR_PORT2_SEL)) begin
         next_state.port2_pin_function_select =
            xdata_req_in.wdata;
      end
      if (wr_hit(xdata_req_in, `ADDR_PORT3_SEL)) begin
         next_state.port3_pin_function_select =
            {xdata_req_in.wdata[`P3_VSYNC_BIT],
             xdata_req_in.wdata[`P3_HSYNC_BIT]};
      end
      if (wr_hit(xdata_req_in, `ADDR_PARA_LOW)) begin
         next_state.parabola_period[7:0] =
            xdata_req_in.wdata;
      end
      if (wr_hit(xdata_req_in, `ADDR_PARA_HIGH)) begin
         next_state.parabola_period[`PARA_WIDTH-1:8] =
            xdata_req_in.wdata[`PARA_HIGH_WIDTH-1:0];
      end
      if (wr_hit(xdata_req_in, `ADDR_IRQ_MASK)) begin
         next_state.irq_enable_mask =
            xdata_req_in.wdata[`IRQ_COUNT-1:0];
      end
      if (wr_hit(xdata_req_in, `ADDR_SOA_LOW)) begin
         next_state.safe_area_low_threshold =
            xdata_req_in.wdata[`SOA_WIDTH-1:0];
      end

      // Port 1 pin routing
      for (int i = 0; i < 8; i++) begin
         next_state.port1_pins[i] =
            state.port1_pin_function_select[i] ?
            pwm_in[i] : port1_data_in[i];
      end

      // Port 2 pin routing
      next_state.port2_pins = port2_data_in;
      for (int i = 0; i < `P2_PWM_BITS; i++) begin
         if (state.port2_pin_function_select[i]) begin
            next_state.port2_pins[i] = pwm_in[8 + i];
         end
      end
      if (state.port2_pin_function_select[`P2_CLAMP_BIT]) begin
         next_state.port2_pins[`P2_CLAMP_BIT] = hclamp_in;
      end
      next_state.port2_analog =
         state.port2_pin_function_select[7:`P2_ADC_LSB];
      for (int i = 0; i < 4; i++) begin
         if (state.port2_pin_function_select[`P2_ADC_LSB + i]) begin
            next_state.port2_pins[`P2_ADC_LSB + i] = 1'b1;
         end
      end

      // Port 3 pin routing
      next_state.port3_pins = port3_data_in;
      if (state.port3_pin_function_select[0]) begin
         next_state.port3_pins[`P3_HSYNC_BIT] =
            horizontal_sync_out_in;
      end
      if (state.port3_pin_function_select[1]) begin
         next_state.port3_pins[`P3_VSYNC_BIT] =
            vertical_sync_out_in;
      end
   end

   // ==========================================================
   // Registers
   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state.port1_pin_function_select <= `RST_PIN_SELECT;
         state.port2_pin_function_select <= `RST_PIN_SELECT;
         state.port3_pin_function_select <= 2'h0;
         state.parabola_period           <= `RST_PARA;
         state.irq_enable_mask           <= `RST_IRQ_MASK;
         state.safe_area_low_threshold   <= `RST_SOA_LOW;
         state.vsync_absent_seen         <= 1'b0;
         state.read_data                 <= `RST_READ_DATA;
         state.port1_pins                <= 8'h00;
         state.port2_pins                <= 8'h00;
         state.port2_analog              <= 4'h0;
         state.port3_pins                <= 8'h00;
      end else begin
         state <= next_state;
      end
   end

   // ==========================================================
   // Outputs
   assign xdata_rdata_out       = state.read_data;
   assign irq_out               = irq_req;
   assign port1_pin_out         = state.port1_pins;
   assign port2_pin_out         = state.port2_pins;
   assign port2_analog_out      = state.port2_analog;
   assign port3_pin_out         = state.port3_pins;
   assign parabola_period_out   = state.parabola_period;
   assign soa_low_threshold_out = state.safe_area_low_threshold;

endmodule : monitor_periph_status_regs

// ### verification/cpu_xdata_model.sv
// Bus model of the embedded core issuing external data accesses
`timescale 1ns/1ps

module cpu_xdata_model (
   // Clock
   input  wire logic                       ref_clk_in,
   // Access request and answer
   output var monitor_periph_pkg::xdata_req_s xdata_req_out,
   input  wire logic [7:0]                 xdata_rdata_in
);
   import monitor_periph_pkg::*;

   initial xdata_req_out = '0;

   // ==========================================================
   // One write, strobe for one cycle
   task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
      @(posedge ref_clk_in);
      xdata_req_out <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
      @(posedge ref_clk_in);
      xdata_req_out <= '0;
   endtask : write_reg

   // ==========================================================
   // One read, data taken once the answer edge has settled
   task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
      @(posedge ref_clk_in);
      xdata_req_out <= '{addr: addr, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge ref_clk_in);
      xdata_req_out <= '0;
      #1 data = xdata_rdata_in;
   endtask : read_reg
endmodule : cpu_xdata_model

// ### verification/monitor_periph_status_regs_asserts.sv
// Assertion checker for the monitor register bank
`timescale 1ns/1ps
`include "monitor_periph_map.svh"

module monitor_periph_status_regs_asserts (
   // Clock and reset
   input wire logic                             ref_clk_in,
   input wire logic                             rst_b_in,
   // CPU access
   input wire monitor_periph_pkg::xdata_req_s   xdata_req_in,
   input wire logic [7:0]                       xdata_rdata_out,
   input wire logic                             irq_out,
   // Status and events
   input wire monitor_periph_pkg::sync_status_s sync_status_in,
   input wire logic                             vsync_pulse_in,
   input wire logic [`SOA_WIDTH-1:0]            soa_high_threshold_in,
   input wire logic                             clock_line_low_in,
   input wire logic                             conversion_done_in,
   input wire logic                             display_empty_in,
   input wire logic                             safe_area_event_in,
   input wire logic                             parabola_tick_in,
   // Register contents
   input wire logic [`PARA_WIDTH-1:0]           parabola_period_out,
   input wire logic [`SOA_WIDTH-1:0]            soa_low_threshold_out
);
   import monitor_periph_pkg::*;

   // ==========================================================
   // Reference flags and mask
   logic [5:0] flags_h;
   logic [5:0] mask_h;
   logic [5:0] set_h;
   logic [5:0] clr_h;
   logic [7:0] exp_rd;
   logic       vprev;
   logic       live;
   logic       mask_wq;
   wire        wr_on = xdata_req_in.wr;
   wire [7:0]  adr = xdata_req_in.addr;
   wire        wr_mask = wr_on && adr == `ADDR_IRQ_MASK;
   wire        status_rd = xdata_req_in.rd && adr inside {8'h82, 8'h83,
               8'h84, 8'h87, 8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8E, 8'h91};

   assign set_h = {parabola_tick_in,
                   vsync_pulse_in | (sync_status_in.vsync_absent & ~vprev),
                   safe_area_event_in, display_empty_in,
                   conversion_done_in, clock_line_low_in};
   assign clr_h = ((wr_on && adr == `ADDR_IRQ_CLEAR) ?
                   xdata_req_in.wdata[5:0] : 6'h00) |
                  ((wr_on && adr == `ADDR_SOA_CLEAR) ? 6'h08 : 6'h00);

   always_comb begin
      case (adr)
         `ADDR_HCOUNT_LOW:  exp_rd = sync_status_in.hcount[7:0];
         `ADDR_HCOUNT_HIGH: exp_rd = {sync_status_in.hsync_input_polarity,
            sync_status_in.hsync_absent, 2'b00, sync_status_in.hcount[11:8]};
         `ADDR_VCOUNT_LOW:  exp_rd = sync_status_in.vcount[7:0];
         `ADDR_VCOUNT_HIGH: exp_rd = {sync_status_in.vsync_input_polarity,
            sync_status_in.vsync_absent, 2'b00, sync_status_in.vcount[11:8]};
         default:           exp_rd = 8'h00;
      endcase
   end

   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         flags_h <= 6'h00;
         mask_h  <= 6'h00;
         vprev   <= 1'b0;
         live    <= 1'b0;
         mask_wq <= 1'b0;
      end else begin
         flags_h <= (flags_h & ~clr_h) | set_h;
         mask_h  <= wr_mask ? xdata_req_in.wdata[5:0] : mask_h;
         vprev   <= sync_status_in.vsync_absent;
         live    <= 1'b1;
         mask_wq <= wr_mask;
      end
   end

   // ==========================================================
   // Properties
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!rst_b_in);

   sequence s_read(a);
      xdata_req_in.rd && adr == a;
   endsequence
   sequence s_absent_held;
      sync_status_in.vsync_absent [*2];
   endsequence

   a_status_read: assert property (
      status_rd |=> xdata_rdata_out == $past(exp_rd))
      else $error("Status register read wrong");
   a_irq_request: assert property (
      live && !mask_wq |-> irq_out == |(flags_h & mask_h))
      else $error("Interrupt request wrong");
   a_flag_read: assert property (
      s_read(`ADDR_IRQ_FLAGS) |=> xdata_rdata_out == {2'b00, $past(flags_h)})
      else $error("Flag read wrong");
   a_mask_read: assert property (
      s_read(`ADDR_IRQ_MASK) |=> xdata_rdata_out == {2'b00, $past(mask_h)})
      else $error("Mask read wrong");
   a_vertical_event_irq_once: assert property (
      s_absent_held ##0 (live && !vsync_pulse_in && mask_h[4] &&
      !flags_h[4] &&
      (((flags_h & ~clr_h) | set_h) & mask_h & 6'h2F) == 6'h00)
      |=> !irq_out)
      else $error("Vertical event repeated");
   a_para_write: assert property (
      wr_on && adr == `ADDR_PARA_LOW |=>
      parabola_period_out[7:0] == $past(xdata_req_in.wdata))
      else $error("Period low write lost");
   a_para_read: assert property (
      s_read(`ADDR_PARA_HIGH) |=>
      xdata_rdata_out == {3'b000, $past(parabola_period_out[12:8])})
      else $error("Period high read wrong");
   a_soa_read: assert property (
      s_read(`ADDR_SOA_LOW) |=> xdata_rdata_out ==
      $past({sync_status_in.hcount[11:6] < soa_high_threshold_in,
      sync_status_in.hcount[11:6] > soa_low_threshold_out,
      soa_low_threshold_out}))
      else $error("Safe area read wrong");
   a_soa_clear: assert property (
      wr_on && adr == `ADDR_SOA_CLEAR && set_h == 6'h00 &&
      flags_h[3] && mask_h[3] && (flags_h & mask_h & 6'h37) == 6'h00 &&
      !wr_mask |=> !irq_out)
      else $error("Safe area flag not cleared");
endmodule : monitor_periph_status_regs_asserts

bind monitor_periph_status_regs monitor_periph_status_regs_asserts u_asserts (
   .ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
   .xdata_req_in(xdata_req_in), .xdata_rdata_out(xdata_rdata_out),
   .irq_out(irq_out), .sync_status_in(sync_status_in),
   .vsync_pulse_in(vsync_pulse_in),
   .soa_high_threshold_in(soa_high_threshold_in),
   .clock_line_low_in(clock_line_low_in),
   .conversion_done_in(conversion_done_in),
   .display_empty_in(display_empty_in),
   .safe_area_event_in(safe_area_event_in),
   .parabola_tick_in(parabola_tick_in),
   .parabola_period_out(parabola_period_out),
   .soa_low_threshold_out(soa_low_threshold_out));

// ### verification/tb_monitor_periph_status_regs.sv
// Self-checking bench for the monitor register bank
`timescale 1ns/1ps
`include "monitor_periph_map.svh"

module tb_monitor_periph_status_regs;
   import monitor_periph_pkg::*;

   typedef struct packed {
      logic [7:0] waddr;
      logic [7:0] wdata;
      logic [7:0] raddr;
      logic [7:0] exp;
   } row_s;

   logic         clk = 1'b0;
   logic         rst_b = 1'b0;
   xdata_req_s   req;
   logic [7:0]   rdata, p1, p2, p3, got;
   logic [3:0]   analog;
   logic         irq;
   sync_status_s sync = '{12'hA5C, 1'b1, 1'b1, 12'h3C7, 1'b0, 1'b1};
   logic [5:0]   ev = 6'h00;
   logic [10:0]  pwm = 11'h5A3;
   logic [1:0]   sync_out = 2'b10;
   int           bad_count = 0;
   int           checks_done = 0;
   row_s rows [15] = '{
      '{8'h8B, 8'h55, 8'h8F, 8'h00}, '{8'h8B, 8'h55, 8'h85, 8'h00},
      '{8'h8B, 8'h55, 8'h90, 8'h00}, '{8'h85, 8'hA5, 8'h85, 8'hA5},
      '{8'h86, 8'hFF, 8'h86, 8'h1F}, '{8'h8F, 8'h3F, 8'h8F, 8'h3F},
      '{8'h82, 8'hFF, 8'h82, 8'h00}, '{8'h83, 8'hFF, 8'h83, 8'h00},
      '{8'h87, 8'hFF, 8'h87, 8'h5C}, '{8'h8B, 8'h00, 8'h88, 8'hCA},
      '{8'h8A, 8'hFF, 8'h89, 8'hC7}, '{8'h8B, 8'h00, 8'h8A, 8'h83},
      '{8'h8C, 8'h2A, 8'h8C, 8'hAA}, '{8'h8C, 8'h28, 8'h8C, 8'hE8},
      '{8'h8B, 8'h55, 8'h8B, 8'h00}};

   always #20 clk = ~clk;

   cpu_xdata_model cpu (.ref_clk_in(clk), .xdata_req_out(req),
                        .xdata_rdata_in(rdata));

   monitor_periph_status_regs dut (
      .ref_clk_in(clk), .rst_b_in(rst_b), .xdata_req_in(req),
      .xdata_rdata_out(rdata), .irq_out(irq), .sync_status_in(sync),
      .vsync_pulse_in(ev[4]), .soa_high_threshold_in(6'h30),
      .clock_line_low_in(ev[0]), .conversion_done_in(ev[1]),
      .display_empty_in(ev[2]), .safe_area_event_in(ev[3]),
      .parabola_tick_in(ev[5]), .port1_data_in(8'h3C),
      .port2_data_in(8'h00), .port3_data_in(8'hE9), .pwm_in(pwm),
      .hclamp_in(1'b1), .horizontal_sync_out_in(sync_out[0]),
      .vertical_sync_out_in(sync_out[1]), .port1_pin_out(p1),
      .port2_pin_out(p2), .port2_analog_out(analog), .port3_pin_out(p3),
      .parabola_period_out(), .soa_low_threshold_out());

   // ==========================================================
   // Compare and report
   task automatic check_byte(input string nm, input logic [7:0] e,
                             input logic [7:0] g);
      checks_done++;
      if (g !== e) begin
         bad_count++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : check_byte

   task automatic check_bit(input string nm, input logic e, input logic g);
      check_byte(nm, {7'h00, e}, {7'h00, g});
   endtask : check_bit

   task automatic results;
      $display("Checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : results

   task automatic pulse(input logic [5:0] v);
      @(posedge clk) ev <= v;
      @(posedge clk) ev <= 6'h00;
      #1;
   endtask : pulse

   initial begin
      repeat (5000) @(posedge clk);
      bad_count++;
      $display("Error run_time expected finish seen timeout");
      results();
   end

   // ==========================================================
   // Main sequence
   initial begin
      repeat (4) @(posedge clk);
      #1 check_byte("rdata reset", 8'h00, rdata);
      check_bit("irq reset", 1'b0, irq);
      check_byte("port1 reset", 8'h00, p1);
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      $display("Test reset done");
      foreach (rows[i]) begin
         cpu.write_reg(rows[i].waddr, rows[i].wdata);
         cpu.read_reg(rows[i].raddr, got);
         check_byte("read", rows[i].exp, got);
      end
      $display("Test table done");
      cpu.write_reg(`ADDR_PORT1_SEL, 8'hF0);
      cpu.write_reg(`ADDR_PORT2_SEL, 8'hFD);
      cpu.write_reg(`ADDR_PORT3_SEL, 8'hFF);
      repeat (2) @(posedge clk);
      #1 check_byte("port1 pins", 8'hAC, p1);
      check_byte("port2 pins", 8'hFD, p2);
      check_byte("port2 analog", 8'h0F, {4'h0, analog});
      check_byte("port3 pins", 8'hF1, p3);
      @(posedge clk) sync_out <= 2'b01;
      repeat (2) @(posedge clk);
      #1 check_byte("port3 follow", 8'hE9, p3);
      cpu.write_reg(`ADDR_PORT1_SEL, 8'h00);
      repeat (2) @(posedge clk);
      #1 check_byte("port1 data", 8'h3C, p1);
      $display("Test pins done");
      for (int i = 0; i < 6; i++) begin
         pulse(6'h01 << i);
         check_bit("irq set", 1'b1, irq);
         cpu.write_reg(`ADDR_IRQ_CLEAR, 8'h00);
         cpu.read_reg(`ADDR_IRQ_FLAGS, got);
         check_byte("flag", 8'h01 << i, got);
         if (i == 3) cpu.write_reg(`ADDR_SOA_CLEAR, 8'h00);
         else cpu.write_reg(`ADDR_IRQ_CLEAR, 8'h01 << i);
         cpu.read_reg(`ADDR_IRQ_FLAGS, got);
         check_byte("flag clear", 8'h00, got);
         check_bit("irq clear", 1'b0, irq);
      end
      $display("Test sources done");
      cpu.write_reg(`ADDR_IRQ_MASK, 8'h3D);
      pulse(6'h02);
      check_bit("irq masked", 1'b0, irq);
      cpu.write_reg(`ADDR_IRQ_MASK, 8'h3F);
      repeat (2) @(posedge clk);
      #1 check_bit("irq unmasked", 1'b1, irq);
      cpu.write_reg(`ADDR_IRQ_CLEAR, 8'h02);
      $display("Test mask done");
      @(posedge clk) sync.vsync_absent <= 1'b1;
      repeat (3) @(posedge clk);
      cpu.read_reg(`ADDR_IRQ_FLAGS, got);
      check_byte("absent event", 8'h10, got);
      cpu.write_reg(`ADDR_IRQ_CLEAR, 8'h10);
      repeat (6) @(posedge clk);
      cpu.read_reg(`ADDR_IRQ_FLAGS, got);
      check_byte("absent once", 8'h00, got);
      @(posedge clk) sync.vsync_absent <= 1'b0;
      $display("Test vertical done");
      results();
   end
endmodule : tb_monitor_periph_status_regs
